//--- inc/event_dio_pkg.sv
// shared constants and the state type of the event clear, sag/surge and pin config block
package event_dio_pkg;

  // ==========================================
  // register offsets
  localparam logic [15:0] OFS_PIN_FUNC = 16'h0046;
  localparam logic [15:0] OFS_EVENT_CLEAR = 16'h0092;
  localparam logic [15:0] OFS_THERM_VOLT = 16'h001A;

  // ==========================================
  // event bit positions
  localparam int EV_TOP = 15;
  localparam int EV_SLOW_LOW = 8;
  localparam int EV_DIP = 7;
  localparam int EV_SPIKE = 6;
  localparam logic [15:0] EV_IMPL_MASK = 16'hFFC0;

  // ==========================================
  // pin function codes and field layout
  localparam int PIN_COUNT = 4;
  localparam int CODE_W = 3;
  localparam int CFG_W = 12;
  localparam logic [2:0] CODE_STD = 3'h5;
  localparam logic [2:0] CODE_CRIT = 3'h4;
  localparam logic [2:0] CODE_SPECIAL = 3'h3;
  localparam logic [2:0] CODE_INPUT = 3'h2;
  localparam logic [11:0] CFG_RESET = 12'h0492;
  localparam int THERM_PIN = 2;

  // ==========================================
  // whole state of the block
  typedef struct packed {
    logic [11:0] cfg;
    logic [15:0] clr;
    logic [15:0] flags;
    logic [15:0] test;
    logic multi;
    logic strap_done;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] therm;
    logic [3:0] sys_word;
    logic [1:0] addr_bits;
    logic std_out;
    logic crit_out;
  } state_t;

endpackage

//--- logic/event_dio_core.sv
// event clear, fast sag/surge detection and configurable pin control
//
// Summary of operation
// R1: writing one clears matching latched event flag
// R2: unimplemented clear and config bits read zero
// R3: other events evaluated once per computation cycle
// R4: sag and surge checked at every data-ready
// R5: trailing mean square compared to both limits
// R6: sag and surge set without hold qualification
// R7: masked sag or surge drives notification pin high
// R8: events stay latched until host clears them
// R9: notification pins follow their class event masks
// R10: pins default to input, mirrored in status
// R11: strap low at reset makes pins 0-1 address
// R12: strap high allows any code on pins 0-1
// R13: temperature code on pin 2 fills thermistor register
// R14: pin 2 output role reports thermistor zero
// R15: three-bit function code per pin, fixed positions
// R16: codes 101 standard, 100 critical, 010 input
// R17: code 011 temperature on pin 2, address 0-1
// R18: clear bits self-return after flag and test clear
// R19: clearing a forced event also drops test bit
// R20: multi-device mode ignores codes for pins 0-1
`timescale 1ns/100ps
`default_nettype none

module event_dio_core #(
  parameter int MS_W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic compute_tick,
  input wire logic [7:0] slow_cond,
  input wire logic data_ready,
  input wire logic [MS_W-1:0] trailing_ms,
  input wire logic [MS_W-1:0] dip_limit,
  input wire logic [MS_W-1:0] spike_limit,
  input wire logic [15:0] test_set,
  input wire logic [15:0] std_mask,
  input wire logic [15:0] crit_mask,
  input wire logic mode_strap,
  input wire logic [15:0] therm_adc,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [15:0] event_flags,
  output logic [15:0] event_test,
  output logic [3:0] system_state_word,
  output logic bus_addr_bit_0,
  output logic bus_addr_bit_1,
  output logic multi_device
);

  // ==========================================
  // state and effective pin functions
  event_dio_pkg::state_t cur;
  event_dio_pkg::state_t next_cur;
  logic [2:0] eff_code [event_dio_pkg::PIN_COUNT];
  logic [15:0] clear_now;
  logic [15:0] set_now;
  logic dip_hit;
  logic spike_hit;

  // pins 0-1 are address inputs in multi mode whatever the stored code says
  always_comb begin
    for (int i = 0; i < event_dio_pkg::PIN_COUNT; i++) begin
      eff_code[i] = cur.cfg[i*event_dio_pkg::CODE_W +: event_dio_pkg::CODE_W]; // R15
      if (i < 2 && cur.multi) begin
        eff_code[i] = event_dio_pkg::CODE_SPECIAL; // R11
      end
    end
  end

  assign dip_hit = data_ready && (trailing_ms < dip_limit); // R4 R5
  assign spike_hit = data_ready && (trailing_ms > spike_limit); // R4 R5

  // ==========================================
  // next-state logic
  always_comb begin
    next_cur = cur;
    clear_now = 16'h0000;
    if (reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR) begin
      clear_now = reg_wdata & event_dio_pkg::EV_IMPL_MASK; // R1 R2
    end
    set_now = 16'h0000;
    if (compute_tick) begin
      set_now[event_dio_pkg::EV_TOP:event_dio_pkg::EV_SLOW_LOW] = slow_cond; // R3
    end
    // no hold counter: a single data-ready comparison sets the flag
    set_now[event_dio_pkg::EV_DIP] = dip_hit; // R6
    set_now[event_dio_pkg::EV_SPIKE] = spike_hit; // R6

    // set beats clear so an event in the clearing cycle is kept
    next_cur.test = ((cur.test & ~clear_now) | test_set) & event_dio_pkg::EV_IMPL_MASK; // R19
    next_cur.flags = ((cur.flags & ~clear_now) | set_now | test_set) & event_dio_pkg::EV_IMPL_MASK; // R8 R1
    next_cur.clr = (clear_now | (cur.clr & (cur.flags | cur.test))) & event_dio_pkg::EV_IMPL_MASK; // R18

    // strap caught once, on the first edge after reset release
    if (!cur.strap_done) begin
      next_cur.strap_done = 1'b1;
      next_cur.multi = ~mode_strap; // R11 R12
    end

    if (reg_wr && reg_addr == event_dio_pkg::OFS_PIN_FUNC) begin
      next_cur.cfg = reg_wdata[event_dio_pkg::CFG_W-1:0]; // R15
      if (cur.multi) begin
        next_cur.cfg[5:0] = cur.cfg[5:0]; // R20
      end
    end

    next_cur.rvalid = reg_rd;
    next_cur.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        event_dio_pkg::OFS_PIN_FUNC: next_cur.rdata = {4'h0, cur.cfg}; // R2
        event_dio_pkg::OFS_EVENT_CLEAR: next_cur.rdata = cur.clr & event_dio_pkg::EV_IMPL_MASK; // R2
        event_dio_pkg::OFS_THERM_VOLT: next_cur.rdata = cur.therm;
        default: next_cur.rdata = 16'h0000;
      endcase
    end

    next_cur.std_out = |(cur.flags & std_mask); // R7 R9
    next_cur.crit_out = |(cur.flags & crit_mask); // R7 R9

    if (eff_code[event_dio_pkg::THERM_PIN] == event_dio_pkg::CODE_SPECIAL) begin
      next_cur.therm = therm_adc; // R13
    end else begin
      next_cur.therm = 16'h0000; // R14
    end

    for (int i = 0; i < event_dio_pkg::PIN_COUNT; i++) begin
      next_cur.sys_word[i] = (eff_code[i] == event_dio_pkg::CODE_INPUT) ? pin_in[i] : 1'b0; // R10
    end
    next_cur.addr_bits[0] = (eff_code[0] == event_dio_pkg::CODE_SPECIAL) ? pin_in[0] : 1'b0; // R17
    next_cur.addr_bits[1] = (eff_code[1] == event_dio_pkg::CODE_SPECIAL) ? pin_in[1] : 1'b0; // R17
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      cur.cfg <= event_dio_pkg::CFG_RESET; // R10
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================
  // pin drivers; unused codes leave the pin undriven
  always_comb begin
    for (int i = 0; i < event_dio_pkg::PIN_COUNT; i++) begin
      pin_oe[i] = 1'b0;
      pin_out[i] = 1'b0;
      if (eff_code[i] == event_dio_pkg::CODE_STD) begin
        pin_oe[i] = 1'b1; // R16
        pin_out[i] = cur.std_out; // R9
      end else if (eff_code[i] == event_dio_pkg::CODE_CRIT) begin
        pin_oe[i] = 1'b1; // R16
        pin_out[i] = cur.crit_out; // R9
      end
    end
  end

  assign reg_rdata = cur.rdata;
  assign reg_rvalid = cur.rvalid;
  assign event_flags = cur.flags;
  assign event_test = cur.test;
  assign system_state_word = cur.sys_word;
  assign bus_addr_bit_0 = cur.addr_bits[0];
  assign bus_addr_bit_1 = cur.addr_bits[1];
  assign multi_device = cur.multi;

  // ==========================================
  // checks
  a_clear_drops_flag: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && reg_wdata[15] && !compute_tick && !test_set[15])
    |=> !event_flags[15])
    else $error("written clear bit did not drop its flag");

  a_unimpl_reads_zero: assert property (@(posedge clk) disable iff (sys_rst) // R2
    reg_rvalid |->
      ($past(reg_addr) != event_dio_pkg::OFS_EVENT_CLEAR || reg_rdata[5:0] == 6'h00)
      && ($past(reg_addr) != event_dio_pkg::OFS_PIN_FUNC || reg_rdata[15:12] == 4'h0))
    else $error("unimplemented bits read nonzero");

  a_slow_only_tick: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (!compute_tick && test_set[9] == 1'b0 && !event_flags[9]) |=> !event_flags[9])
    else $error("slow event set without a computation tick");

  a_dip_on_ready: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (data_ready && trailing_ms < dip_limit) |=> event_flags[7])
    else $error("sag not flagged on data ready");

  a_spike_on_ready: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (data_ready && trailing_ms > spike_limit) |=> event_flags[6])
    else $error("surge not flagged on data ready");

  a_event_stays_latched: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (event_flags[7] && !(reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && reg_wdata[7]))
    |=> event_flags[7])
    else $error("latched event lost without clear");

  a_std_pin_follows: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (|(event_flags & std_mask) && $stable(std_mask) && eff_code[3] == event_dio_pkg::CODE_STD)
    |=> ##0 (eff_code[3] != event_dio_pkg::CODE_STD || (pin_out[3] && pin_oe[3])))
    else $error("standard pin not driven for masked event");

  a_input_not_driven: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (eff_code[2] == event_dio_pkg::CODE_INPUT) |-> !pin_oe[2])
    else $error("input-role pin is driven");

  a_multi_keeps_cfg: assert property (@(posedge clk) disable iff (sys_rst) // R20
    (multi_device && reg_wr && reg_addr == event_dio_pkg::OFS_PIN_FUNC) |=> $stable(cur.cfg[5:0]))
    else $error("address pin codes changed in multi mode");

  a_therm_zero_out: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (eff_code[2] == event_dio_pkg::CODE_STD || eff_code[2] == event_dio_pkg::CODE_CRIT) |=> cur.therm == 16'h0000)
    else $error("thermistor value nonzero with pin 2 as output");

  a_test_bit_cleared: assert property (@(posedge clk) disable iff (sys_rst) // R19
    (reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && reg_wdata[8] && !test_set[8]) |=> !event_test[8])
    else $error("forcing test bit survived a clear");

  a_clear_bit_returns: assert property (@(posedge clk) disable iff (sys_rst) // R18
    (cur.clr[10] && !event_flags[10] && !event_test[10]
      && !(reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && reg_wdata[10])) |=> !cur.clr[10])
    else $error("clear bit did not return to zero");

  // ==========================================
  // further checks; mirror checks wait for strap_done because the edge
  // that releases reset still holds the reset state and must not be judged
  a_crit_pin_follows: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (|(event_flags & crit_mask) && eff_code[2] == event_dio_pkg::CODE_CRIT)
    |=> (eff_code[2] != event_dio_pkg::CODE_CRIT || (pin_out[2] && pin_oe[2])))
    else $error("critical pin not driven for masked event");

  a_std_pin_quiet: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (!(|(event_flags & std_mask)) && eff_code[3] == event_dio_pkg::CODE_STD)
    |=> !pin_out[3])
    else $error("standard pin active with no masked event");

  a_dip_needs_ready: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (!data_ready && !test_set[7] && !event_flags[7])
    |=> !event_flags[7])
    else $error("sag flag set without data ready");

  a_spike_needs_ready: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (!data_ready && !test_set[6] && !event_flags[6])
    |=> !event_flags[6])
    else $error("surge flag set without data ready");

  a_spike_strict: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (data_ready && trailing_ms <= spike_limit && !test_set[6] && !event_flags[6])
    |=> !event_flags[6])
    else $error("surge flagged at or below its limit");

  a_slow_on_tick: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (compute_tick && slow_cond[0])
    |=> event_flags[8])
    else $error("slow event missed on computation tick");

  a_spike_no_hold: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (data_ready && trailing_ms > spike_limit && !event_flags[6])
    |=> $rose(event_flags[6]))
    else $error("surge flag not set at once");

  a_loose_bits_zero: assert property (@(posedge clk) disable iff (sys_rst) // R2
    event_flags[5:0] == 6'h00
    && event_test[5:0] == 6'h00)
    else $error("unimplemented event bits nonzero");

  a_multi_from_strap: assert property (@(posedge clk) disable iff (sys_rst) // R11 R12
    $rose(cur.strap_done)
    |-> multi_device == !$past(mode_strap))
    else $error("mode does not follow the strap");

  a_multi_holds: assert property (@(posedge clk) disable iff (sys_rst) // R20
    cur.strap_done
    |=> $stable(multi_device))
    else $error("mode changed after strap sampling");

  a_addr_pin_mirror: assert property (@(posedge clk) disable iff (sys_rst) // R17
    (cur.strap_done && eff_code[0] == event_dio_pkg::CODE_SPECIAL)
    |=> bus_addr_bit_0 == $past(pin_in[0]))
    else $error("address bit does not follow its pin");

  a_addr_zero_else: assert property (@(posedge clk) disable iff (sys_rst) // R17
    (eff_code[1] != event_dio_pkg::CODE_SPECIAL)
    |=> !bus_addr_bit_1)
    else $error("address bit set outside address role");

  a_multi_addr_role: assert property (@(posedge clk) disable iff (sys_rst) // R11
    multi_device |-> (eff_code[0] == event_dio_pkg::CODE_SPECIAL && eff_code[1] == event_dio_pkg::CODE_SPECIAL
      && !pin_oe[0] && !pin_oe[1]))
    else $error("address pins not in address role");

  a_input_mirrored: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (cur.strap_done && eff_code[3] == event_dio_pkg::CODE_INPUT)
    |=> system_state_word[3] == $past(pin_in[3]))
    else $error("input pin level not mirrored");

  a_other_not_mirrored: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (eff_code[1] != event_dio_pkg::CODE_INPUT)
    |=> !system_state_word[1])
    else $error("non-input pin mirrored in status");

  a_therm_follows: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (cur.strap_done && eff_code[2] == event_dio_pkg::CODE_SPECIAL)
    |=> cur.therm == $past(therm_adc))
    else $error("thermistor value does not follow the sensor");

  a_out_code_drives: assert property (@(posedge clk) disable iff (sys_rst) // R16
    (eff_code[3] == event_dio_pkg::CODE_STD || eff_code[3] == event_dio_pkg::CODE_CRIT)
    |-> pin_oe[3])
    else $error("notification pin not driven");

  a_unused_undriven: assert property (@(posedge clk) disable iff (sys_rst) // R16
    (eff_code[1] != event_dio_pkg::CODE_STD && eff_code[1] != event_dio_pkg::CODE_CRIT)
    |-> (!pin_oe[1] && !pin_out[1]))
    else $error("pin driven outside notification role");

  a_cfg_write_lands: assert property (@(posedge clk) disable iff (sys_rst) // R15
    (reg_wr && reg_addr == event_dio_pkg::OFS_PIN_FUNC && !multi_device)
    |=> cur.cfg == $past(reg_wdata[11:0]))
    else $error("pin function write did not land");

  a_clear_bit_sets: assert property (@(posedge clk) disable iff (sys_rst) // R18
    (reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && reg_wdata[9])
    |=> cur.clr[9])
    else $error("written clear bit not shown");

  a_zero_write_keeps: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (event_flags[8] && reg_wr && reg_addr == event_dio_pkg::OFS_EVENT_CLEAR && !reg_wdata[8])
    |=> event_flags[8])
    else $error("zero clear bit dropped its flag");

endmodule

`default_nettype wire

//--- bench/host_model.sv
// host side of the register port: strobed single-word writes and reads
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    {reg_addr, reg_wdata} = 32'h0000_0000;
    {reg_wr, reg_rd} = 2'h0;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // idle data is scrambled so a stale word never looks valid
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rvalid ? reg_rdata : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

//--- bench/tb_event_dio_core.sv
// self-checking bench for the event clear, sag/surge and pin config block
`timescale 1ns/100ps
`default_nettype none
module tb_event_dio_core;
  localparam logic [15:0] A_CFG = event_dio_pkg::OFS_PIN_FUNC;
  localparam logic [15:0] A_CLR = event_dio_pkg::OFS_EVENT_CLEAR;
  localparam logic [15:0] A_TH = event_dio_pkg::OFS_THERM_VOLT;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, compute_tick, data_ready, mode_strap;
  logic bus_addr_bit_0, bus_addr_bit_1, multi_device;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, test_set, std_mask, crit_mask, therm_adc;
  logic [15:0] event_flags, event_test, rv;
  logic [7:0] slow_cond;
  logic [31:0] trailing_ms, dip_limit, spike_limit;
  logic [3:0] pin_in, pin_out, pin_oe, system_state_word;
  int fail_count = 0;
  int check_count = 0;
  event_dio_core u_event_dio_core (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .compute_tick, .slow_cond, .data_ready, .trailing_ms, .dip_limit, .spike_limit, .test_set,
    .std_mask, .crit_mask, .mode_strap, .therm_adc, .pin_in, .pin_out, .pin_oe, .event_flags, .event_test,
    .system_state_word, .bus_addr_bit_0, .bus_addr_bit_1, .multi_device);
  host_model u_host_model (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    @(posedge clk);
    mode_strap <= strap;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // one-cycle pulse on the event sources, returns once the flags have landed
  task automatic fire(input logic ct, input logic dr, input logic [15:0] ts);
    @(posedge clk);
    {compute_tick, data_ready, test_set} <= {ct, dr, ts};
    @(posedge clk);
    {compute_tick, data_ready, test_set} <= 18'h0_0000;
    #1;
  endtask
  task automatic pins_later(input logic [15:0] exp);
    @(posedge clk);
    #1;
    chk({8'h00, pin_oe, pin_out}, exp);
  endtask
  task automatic t_defaults();
    u_host_model.rd(A_CFG, rv);
    chk(rv, 16'h0492);
    chk({12'h000, pin_oe}, 16'h0000);
    u_host_model.rd(A_CLR, rv);
    chk(rv, 16'h0000);
    u_host_model.rd(16'h0010, rv);
    chk(rv, 16'h0000);
  endtask
  task automatic t_slow();
    @(posedge clk);
    slow_cond <= 8'h81;
    repeat (2) @(posedge clk);
    #1;
    chk(event_flags, 16'h0000);
    fire(1'b1, 1'b0, 16'h0000);
    chk(event_flags, 16'h8100);
    @(posedge clk);
    slow_cond <= 8'h00;
    u_host_model.wr(A_CLR, 16'h8000);
    #1;
    chk(event_flags, 16'h0100);
    u_host_model.wr(A_CLR, 16'h0100);
    #1;
    chk(event_flags, 16'h0000);
  endtask
  task automatic t_dip_spike();
    @(posedge clk);
    {dip_limit, spike_limit, trailing_ms} <= {32'h0000_1000, 32'h0000_8000, 32'h0000_0FFF};
    {std_mask, crit_mask} <= {16'h0080, 16'h0040};
    u_host_model.wr(A_CFG, 16'h0B12);
    fire(1'b0, 1'b1, 16'h0000);
    chk(event_flags, 16'h0080);
    pins_later(16'h00C8);
    @(posedge clk);
    trailing_ms <= 32'h0000_1000;
    fire(1'b0, 1'b1, 16'h0000);
    chk(event_flags, 16'h0080);
    @(posedge clk);
    trailing_ms <= 32'h0000_8001;
    fire(1'b0, 1'b1, 16'h0000);
    chk(event_flags, 16'h00C0);
    pins_later(16'h00CC);
    u_host_model.wr(A_CLR, 16'h00C0);
    #1;
    chk(event_flags, 16'h0000);
    pins_later(16'h00C0);
  endtask
  task automatic t_forced();
    fire(1'b0, 1'b0, 16'h0200);
    chk(event_test | event_flags, 16'h0200);
    u_host_model.wr(A_CLR, 16'h0200);
    #1;
    chk(event_test | event_flags, 16'h0000);
    repeat (2) @(posedge clk);
    u_host_model.rd(A_CLR, rv);
    chk(rv, 16'h0000);
  endtask
  task automatic t_pins();
    @(posedge clk);
    {pin_in, therm_adc} <= {4'hB, 16'h1234};
    u_host_model.wr(A_CFG, 16'hF4D3);
    u_host_model.rd(A_TH, rv);
    chk(rv, 16'h1234);
    u_host_model.rd(A_CFG, rv);
    chk(rv, 16'h04D3);
    chk({13'h0000, system_state_word[3:1]}, 16'h0005);
    chk({15'h0000, bus_addr_bit_0}, 16'h0001);
    chk({12'h000, pin_oe}, 16'h0000);
    u_host_model.wr(A_CFG, 16'h0552);
    u_host_model.rd(A_TH, rv);
    chk(rv, 16'h0000);
    chk({12'h000, pin_oe}, 16'h0004);
  endtask
  task automatic t_multi();
    chk({15'h0000, multi_device}, 16'h0001);
    @(posedge clk);
    pin_in <= 4'h3;
    u_host_model.wr(A_CFG, 16'h0B2D);
    u_host_model.rd(A_CFG, rv);
    chk(rv, 16'h0B12);
    chk({10'h000, pin_oe, bus_addr_bit_1, bus_addr_bit_0}, 16'h0033);
  endtask
  initial begin
    {sys_rst, compute_tick, data_ready, mode_strap} = 4'h9;
    {test_set, std_mask, crit_mask, therm_adc} = 64'h0;
    {trailing_ms, dip_limit, spike_limit} = 96'h0;
    {slow_cond, pin_in} = 12'h000;
    do_reset(1'b1);
    t_defaults();
    t_slow();
    t_dip_spike();
    t_forced();
    t_pins();
    do_reset(1'b0);
    t_multi();
    give_verdict();
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
